// ### inc/uart_buf_pkg.sv
// Package: constants and carriers for the serial data buffer block
package uart_buf_pkg;
   localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
   localparam logic [7:0] SERIAL_DATA_BUFFER_RST  = 8'h00;
   localparam logic [1:0] PRESCALE_DIV12  = 2'h0;
   localparam logic [1:0] PRESCALE_DIV4   = 2'h1;
   localparam logic [1:0] PRESCALE_DIV48  = 2'h2;
   localparam logic [1:0] PRESCALE_EXT8   = 2'h3;
   localparam logic [5:0] DIV12_LAST      = 6'h0B;
   localparam logic [5:0] DIV4_LAST       = 6'h03;
   localparam logic [5:0] DIV48_LAST      = 6'h2F;
   localparam logic [5:0] EXT8_LAST       = 6'h07;
   localparam logic [3:0] FRAME_LAST_BIT  = 4'h9;
   localparam logic [4:0] RX_SAMPLE_HALF  = 5'h01;
   localparam logic       OVF_PER_BIT_LAST = 1'b1;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic       system_clock_select;
      logic [1:0] prescale;
      logic [7:0] reload;
   } timer_cfg_s;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_START = 2'b01,
      TX_DATA  = 2'b11,
      TX_STOP  = 2'b10
   } tx_state_e;
endpackage

// ### src/baud_tick_gen.sv
// Timer 1 style bit-rate generator: prescaler, 8-bit auto reload, halving
`timescale 1ns/1ps
module baud_tick_gen
   import uart_buf_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire timer_cfg_s cfg,
   input  wire logic       ext_rise,
   output logic            bit_tick
);
   logic [5:0] pre_reg;
   logic [7:0] cnt_reg;
   logic       half_reg;
   logic       tclk;
   logic [5:0] pre_last;

   // ***********************************************
   // Clock selection
   // ***********************************************
   // clock source select
   always_comb
   begin
      case (cfg.prescale)
         PRESCALE_DIV12: pre_last = DIV12_LAST;
         PRESCALE_DIV4:  pre_last = DIV4_LAST;
         PRESCALE_DIV48: pre_last = DIV48_LAST;
         default:        pre_last = EXT8_LAST;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         pre_reg <= 6'h00;
      else if (cfg.system_clock_select)
         pre_reg <= 6'h00;
      else if (cfg.prescale != PRESCALE_EXT8 || ext_rise)
         pre_reg <= (pre_reg >= pre_last) ? 6'h00 : pre_reg + 6'h01;
   end

   assign tclk = cfg.system_clock_select ? 1'b1
               : ((cfg.prescale != PRESCALE_EXT8 || ext_rise)
                  && pre_reg >= pre_last);

   // ***********************************************
   // Auto reload timer and halving
   // ***********************************************
   // overflow at 256 minus reload
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cnt_reg <= 8'h00;
      else if (tclk)
         cnt_reg <= (cnt_reg == 8'hFF) ? cfg.reload : cnt_reg + 8'h01;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         half_reg <= 1'b0;
         bit_tick <= 1'b0;
      end
      else
      begin
         bit_tick <= tclk && cnt_reg == 8'hFF && half_reg == OVF_PER_BIT_LAST;
         if (tclk && cnt_reg == 8'hFF)
            half_reg <= ~half_reg;
      end
   end

   a_tick_two_ovf: assert property (
      @(posedge clock) disable iff (sys_rst)
      bit_tick |-> $past(half_reg) && $past(cnt_reg) == 8'hFF && !half_reg)
      else $error("bit tick without prior overflow");
endmodule

// ### src/uart_data_buffer.sv
// Serial data buffer with transmitter, receiver and bit-rate generator
`timescale 1ns/1ps
module uart_data_buffer
   import uart_buf_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire sfr_req_s   sfr_req,
   output logic [7:0]      sfr_rdata,
   input  wire timer_cfg_s timer_cfg,
   input  wire logic       external_reference_clock,
   input  wire logic       receive_done_clear,
   output logic            receive_done_flag,
   output logic            transmit_done_flag,
   output logic            tx_busy,
   input  wire logic       rx_pin,
   output logic            tx_pin
);
   import uart_buf_pkg::*;

   logic       ext_s1_reg, ext_s2_reg, ext_s3_reg;
   logic       rx_s1_reg, rx_s2_reg;
   logic       bit_tick;
   logic       wr_hit, rd_hit;
   tx_state_e  tx_state_reg;
   logic [7:0] tx_shift_reg;
   logic [3:0] tx_cnt_reg;
   logic [7:0] rx_latch_reg;
   logic [7:0] rx_shift_reg;
   logic [3:0] rx_cnt_reg;
   logic       rx_active_reg;
   logic       rx_done_pulse;

   // ***********************************************
   // Input synchronisers
   // ***********************************************
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
         rx_s1_reg  <= 1'b1;
         rx_s2_reg  <= 1'b1;
      end
      else
      begin
         ext_s1_reg <= external_reference_clock;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
         rx_s1_reg  <= rx_pin;
         rx_s2_reg  <= rx_s1_reg;
      end
   end

   baud_tick_gen u_baud
   (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .cfg      (timer_cfg),
      .ext_rise (ext_s2_reg & ~ext_s3_reg),
      .bit_tick (bit_tick)
   );

   // ***********************************************
   // Register access
   // ***********************************************
   // address decode
   assign wr_hit = sfr_req.wr && sfr_req.addr == SERIAL_DATA_BUFFER_ADDR;
   assign rd_hit = sfr_req.rd && sfr_req.addr == SERIAL_DATA_BUFFER_ADDR;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         sfr_rdata <= SERIAL_DATA_BUFFER_RST;
      else if (rd_hit)
         sfr_rdata <= rx_latch_reg;
   end

   // ***********************************************
   // Transmitter
   // ***********************************************
   // write starts frame; reads never touch this path
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= SERIAL_DATA_BUFFER_RST;
         tx_cnt_reg   <= 4'h0;
         tx_pin       <= 1'b1;
         tx_busy      <= 1'b0;
      end
      else
      begin
         case (tx_state_reg)
            TX_IDLE:
            begin
               if (wr_hit)
               begin
                  tx_shift_reg <= sfr_req.wdata;
                  tx_state_reg <= TX_START;
                  tx_busy      <= 1'b1;
               end
            end
            TX_START:
            begin
               if (bit_tick)
               begin
                  tx_pin       <= 1'b0;
                  tx_cnt_reg   <= 4'h0;
                  tx_state_reg <= TX_DATA;
               end
            end
            TX_DATA:
            begin
               if (bit_tick)
               begin
                  tx_pin       <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_cnt_reg   <= tx_cnt_reg + 4'h1;
                  if (tx_cnt_reg == 4'h7)
                     tx_state_reg <= TX_STOP;
               end
            end
            TX_STOP:
            begin
               if (bit_tick)
               begin
                  tx_pin <= 1'b1;
                  if (tx_cnt_reg == FRAME_LAST_BIT)
                  begin
                     tx_state_reg <= TX_IDLE;
                     tx_busy      <= 1'b0;
                  end
                  tx_cnt_reg <= tx_cnt_reg + 4'h1;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // Done flag raised at start of stop bit; a new write clears it
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         transmit_done_flag <= 1'b0;
      else if (tx_state_reg == TX_STOP && bit_tick && tx_cnt_reg == 4'h8)
         transmit_done_flag <= 1'b1;
      else if (wr_hit)
         transmit_done_flag <= 1'b0;
   end

   // ***********************************************
   // Receiver
   // ***********************************************
   // one sample per bit tick
   // No oversampling: the far end must keep its bits aligned to the ticks
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rx_active_reg <= 1'b0;
         rx_cnt_reg    <= 4'h0;
         rx_shift_reg  <= 8'h00;
      end
      else if (!rx_active_reg)
      begin
         rx_cnt_reg   <= 4'h0;
         if (!rx_s2_reg)
            rx_active_reg <= 1'b1;
      end
      else if (bit_tick)
      begin
         rx_cnt_reg   <= rx_cnt_reg + 4'h1;
         if (rx_cnt_reg == 4'h0 && rx_s2_reg)
            rx_active_reg <= 1'b0;
         else if (rx_cnt_reg >= 4'h1 && rx_cnt_reg <= 4'h8)
            rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
         else if (rx_cnt_reg == FRAME_LAST_BIT)
            rx_active_reg <= 1'b0;
      end
   end

   assign rx_done_pulse = rx_active_reg && bit_tick
                          && rx_cnt_reg == FRAME_LAST_BIT;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         rx_latch_reg <= SERIAL_DATA_BUFFER_RST;
      else if (rx_done_pulse && !receive_done_flag)
         rx_latch_reg <= rx_shift_reg;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         receive_done_flag <= 1'b0;
      else if (rx_done_pulse && !receive_done_flag)
         receive_done_flag <= 1'b1;
      else if (receive_done_clear)
         receive_done_flag <= 1'b0;
   end

   // ***********************************************
   // Checks
   // ***********************************************
   // write starts frame
   a_write_starts_tx: assert property (
      @(posedge clock) disable iff (sys_rst)
      (wr_hit && tx_state_reg == TX_IDLE) |=> tx_busy)
      else $error("write did not start transmission");
   a_read_rx_latch: assert property (
      @(posedge clock) disable iff (sys_rst)
      rd_hit |=> sfr_rdata == $past(rx_latch_reg))
      else $error("read did not return receive latch");
   a_overrun_keeps: assert property (
      @(posedge clock) disable iff (sys_rst)
      receive_done_flag |=> $stable(rx_latch_reg))
      else $error("latch changed while flag set");
   a_start_low: assert property (
      @(posedge clock) disable iff (sys_rst)
      (tx_state_reg == TX_START && bit_tick) |=> !tx_pin)
      else $error("start bit not low");
   a_stop_high: assert property (
      @(posedge clock) disable iff (sys_rst)
      (tx_state_reg == TX_STOP && bit_tick) |=> tx_pin)
      else $error("stop bit not high");
   a_read_no_abort: assert property (
      @(posedge clock) disable iff (sys_rst)
      (rd_hit && tx_state_reg == TX_DATA && !bit_tick)
      |=> $stable(tx_shift_reg))
      else $error("read disturbed transmit data");
   a_hold_tx_byte: assert property (
      @(posedge clock) disable iff (sys_rst)
      (tx_state_reg == TX_START) |=> $stable(tx_shift_reg))
      else $error("transmit byte lost before shifting");
   a_idle_line: assert property (
      @(posedge clock) disable iff (sys_rst)
      (tx_state_reg == TX_IDLE) |-> tx_pin)
      else $error("line not idle high");
endmodule

// ### testbench/uart_remote.sv
// Remote serial transceiver model facing the block's serial pins
`timescale 1ns/1ps
module uart_remote
#(
   parameter int BIT_CYCLES = 8
)
(
   input  wire logic clock,
   input  wire logic tx_line,
   output logic      rx_line
);
   logic [7:0] got_byte;
   int         n_frames;
   int         n_stop_bad;

   initial
   begin
      rx_line = 1'b1;
      got_byte = 8'h00;
      n_frames = 0;
      n_stop_bad = 0;
   end

   // ********************
   // Frame decoder
   // ********************
   // start, LSB first, stop
   always
   begin
      @(negedge tx_line);
      // Sample mid-bit so a one-cycle skew still lands safely
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int k = 0; k < 8; k++)
      begin
         repeat (BIT_CYCLES) @(posedge clock);
         got_byte[k] = tx_line;
      end
      repeat (BIT_CYCLES) @(posedge clock);
      if (tx_line !== 1'b1)
         n_stop_bad++;
      n_frames++;
   end

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++)
      begin
         rx_line <= frame[k];
         repeat (BIT_CYCLES) @(posedge clock);
         #1;
      end
   endtask
endmodule

// ### testbench/uart_data_buffer_test.sv
// Self-checking bench for the serial data buffer block
`timescale 1ns/1ps
module uart_data_buffer_test;
   import uart_buf_pkg::*;
   logic       clock, sys_rst, external_reference_clock, receive_done_clear;
   logic       receive_done_flag, transmit_done_flag, tx_busy, rx_pin, tx_pin;
   sfr_req_s   sfr_req;
   timer_cfg_s timer_cfg;
   logic [7:0] sfr_rdata, rd;
   int         n_fail, num_checks;
   timer_cfg_s cfgs [7] = '{{1'b1, 2'h2, 8'hFC}, {1'b1, 2'h0, 8'h96},
      {1'b1, 2'h0, 8'h27}, {1'b0, 2'h0, 8'hFF}, {1'b0, 2'h1, 8'hFF},
      {1'b0, 2'h2, 8'hFF}, {1'b0, 2'h3, 8'hFF}};

   uart_data_buffer uart_data_buffer_i (.clock(clock), .sys_rst(sys_rst),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .timer_cfg(timer_cfg),
      .external_reference_clock(external_reference_clock),
      .receive_done_clear(receive_done_clear),
      .receive_done_flag(receive_done_flag),
      .transmit_done_flag(transmit_done_flag), .tx_busy(tx_busy),
      .rx_pin(rx_pin), .tx_pin(tx_pin));
   uart_remote #(.BIT_CYCLES(8)) uart_remote_i (.clock(clock),
      .tx_line(tx_pin), .rx_line(rx_pin));

   always #5 clock = ~clock;
   // External reference rises every 4 system cycles
   always #20 external_reference_clock = ~external_reference_clock;

   // ********************
   // Shared tasks
   // ********************
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic limit_hit();
      n_fail++;
      $display("wait limit reached");
      test_done();
   endtask

   task automatic sfr_write(input logic [7:0] a, d);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock) #1;
      sfr_req <= '0;
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock) #1;
      sfr_req <= '0;
      @(posedge clock) #1;
      d = sfr_rdata;
   endtask

   task automatic wait_tx_low();
      int i;
      for (i = 0; i < 20000 && tx_pin !== 1'b0; i++) @(posedge clock) #1;
      if (i == 20000)
         limit_hit();
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 20000 && tx_busy !== 1'b0; i++) @(posedge clock) #1;
      if (i == 20000)
         limit_hit();
   endtask

   function automatic int low_len(input timer_cfg_s c);
      int div;
      div = c.system_clock_select ? 1 : (c.prescale == PRESCALE_DIV12) ? 12 :
         (c.prescale == PRESCALE_DIV4) ? 4 :
         (c.prescale == PRESCALE_DIV48) ? 48 : 32;
      // two overflows a bit, start plus eight zero bits
      return 9 * 2 * (256 - int'(c.reload)) * div;
   endfunction

   // Write a byte, answer with a remote byte, poke the bus mid-frame
   task automatic duplex(input logic [7:0] tb_byte, rem_byte);
      int n0;
      n0 = uart_remote_i.n_frames;
      sfr_write(SERIAL_DATA_BUFFER_ADDR, tb_byte);
      wait_tx_low();
      repeat (4) @(posedge clock);
      #1;
      fork
         uart_remote_i.send_byte(rem_byte);
      join_none
      sfr_read(SERIAL_DATA_BUFFER_ADDR, rd);
      sfr_write(SERIAL_DATA_BUFFER_ADDR, 8'hFF);
      wait_idle();
      repeat (100) @(posedge clock);
      #1;
      check("sent byte", uart_remote_i.got_byte, tb_byte);
      check("frame count", uart_remote_i.n_frames, n0 + 1);
      check("tx done", transmit_done_flag, 1'b1);
   endtask

   // ********************
   // Main sequence
   // ********************
   initial
   begin
      int n;
      int stop_base;
      clock = 0;
      external_reference_clock = 0;
      sys_rst = 1;
      receive_done_clear = 0;
      sfr_req = '0;
      timer_cfg = '{system_clock_select: 1'b1, prescale: 2'h0, reload: 8'hFC};
      n_fail = 0;
      num_checks = 0;
      repeat (20) @(posedge clock);
      #1;
      sys_rst = 0;
      check("tx idle", {tx_pin, tx_busy, receive_done_flag}, 3'b100);
      check("tx done reset", transmit_done_flag, 1'b0);
      sfr_read(SERIAL_DATA_BUFFER_ADDR, rd);
      check("reset data", rd, SERIAL_DATA_BUFFER_RST);
      $display("test reset done");
      for (int k = 0; k < 7; k++)
      begin
         timer_cfg <= cfgs[k];
         repeat (2) @(posedge clock) #1;
         sfr_write(SERIAL_DATA_BUFFER_ADDR, 8'h00);
         wait_tx_low();
         n = 0;
         while (tx_pin === 1'b0 && n < 20000)
         begin
            @(posedge clock) #1;
            n++;
         end
         check("low time", n, low_len(cfgs[k]));
         wait_idle();
      end
      $display("test rates done");
      // Slow rates look like bad stops to the fixed-rate remote
      stop_base = uart_remote_i.n_stop_bad;
      timer_cfg <= '{system_clock_select: 1'b1, prescale: 2'h0, reload: 8'hFC};
      repeat (200) @(posedge clock) #1;
      duplex(8'hA5, 8'h3C);
      sfr_read(SERIAL_DATA_BUFFER_ADDR, rd);
      check("rx data", rd, 8'h3C);
      check("rx done", receive_done_flag, 1'b1);
      $display("test duplex done");
      duplex(8'h11, 8'h77);
      sfr_read(SERIAL_DATA_BUFFER_ADDR, rd);
      check("overrun data", rd, 8'h3C);
      receive_done_clear <= 1'b1;
      @(posedge clock) #1;
      receive_done_clear <= 1'b0;
      @(posedge clock) #1;
      check("flag cleared", receive_done_flag, 1'b0);
      duplex(8'hC3, 8'h5A);
      sfr_read(SERIAL_DATA_BUFFER_ADDR, rd);
      check("new rx data", rd, 8'h5A);
      check("stop errors", uart_remote_i.n_stop_bad, stop_base);
      $display("test overrun done");
      test_done();
   end
endmodule
